/* core/spb_pkg.sv */
package spb_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int SPB_ADDR_W = 18;           // 256K locations
  localparam int SPB_LANES  = 4;            // Byte lanes
  localparam int SPB_LANE_W = 9;            // Bits per lane incl. parity
  localparam int SPB_DATA_W = SPB_LANES * SPB_LANE_W;
  localparam int SPB_CNT_W  = 2;            // Burst counter width

  // ****************************************
  // Reset values and lane masks
  // ****************************************
  localparam logic [SPB_CNT_W-1:0]  SPB_CNT_RST  = 2'h0;
  localparam logic [SPB_LANES-1:0]  SPB_LANE_ALL = 4'hF;
  localparam logic [SPB_LANES-1:0]  SPB_LANE_NONE = 4'h0;
  localparam logic [SPB_DATA_W-1:0] SPB_DOUT_RST = 36'h0;

  // Burst state, one-hot
  typedef enum logic [1:0] {
    SPB_DESEL = 2'b01,                      // Deselected, no burst
    SPB_BURST = 2'b10                       // Burst in progress
  } spb_state_t;

  // Chip select group
  typedef struct packed {
    logic select_low_a_n;
    logic select_high_b;
    logic select_low_c_n;
  } spb_sel_t;

  // Write control group
  typedef struct packed {
    logic                 all_bytes_write_n;
    logic                 byte_write_qualify_n;
    logic [SPB_LANES-1:0] lane_write_select_n;
  } spb_wr_t;

endpackage

/* core/spb_sram_port.sv */
`timescale 1ns/1ps
module spb_sram_port #(
  parameter int  ADDR_W   = spb_pkg::SPB_ADDR_W, // Address width
  parameter bit  HAS_SEL_C = 1'b1               // Package has select C
) (
  // Clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RST_N,
  // Address and strobes
  input  wire logic [ADDR_W-1:0]           ADDR,
  input  wire logic                        CPU_ADDR_STROBE_N,
  input  wire logic                        CTRL_ADDR_STROBE_N,
  input  wire logic                        BURST_ADVANCE_N,
  // Selects and write controls
  input  wire spb_pkg::spb_sel_t           SELECT,
  input  wire spb_pkg::spb_wr_t            WRITE,
  // Data pins
  input  wire logic                        OUT_ENABLE_N,
  input  wire logic [spb_pkg::SPB_DATA_W-1:0] DQ_IN,
  output logic      [spb_pkg::SPB_DATA_W-1:0] DQ_OUT,
  output logic                             DQ_OE
);
  import spb_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [SPB_DATA_W-1:0] mem [0:(1<<ADDR_W)-1];   // Cell array

  // ****************************************
  // State
  // ****************************************
  spb_state_t            st_r, st_nxt;            // Burst state
  logic [ADDR_W-1:0]     base_r, base_nxt;        // Captured address
  logic [SPB_CNT_W-1:0]  cnt_r, cnt_nxt;          // Burst counter
  logic                  pend_rd_r, pend_rd_nxt;  // Read awaiting data
  logic [ADDR_W-1:0]     pend_a_r, pend_a_nxt;    // Its address
  logic                  dvalid_r, dvalid_nxt;    // Data register holds read
  logic [SPB_DATA_W-1:0] dout_r, dout_nxt;        // Output data register

  // ****************************************
  // Access decode
  // ****************************************
  logic                  sel;          // Chip selected this edge
  logic                  cpu_start;    // Processor strobe honoured
  logic                  start;        // Any strobe honoured
  logic                  acc_en;       // Array access this edge
  logic                  acc_rd;       // Access is a read
  logic [ADDR_W-1:0]     acc_a;        // Access address
  logic [SPB_LANES-1:0]  lanes;        // Lanes to write

  // Lane enables from the write controls
  function automatic logic [SPB_LANES-1:0] lane_mask(input spb_wr_t w);
    if (!w.all_bytes_write_n) begin
      lane_mask = SPB_LANE_ALL;
    end else if (!w.byte_write_qualify_n) begin
      lane_mask = ~w.lane_write_select_n;
    end else begin
      lane_mask = SPB_LANE_NONE;
    end
  endfunction

  // Select, strobe priority and burst stepping
  always_comb begin
    // Missing select C reads as active
    sel = !SELECT.select_low_a_n && SELECT.select_high_b
          && (!HAS_SEL_C || !SELECT.select_low_c_n);
    // Processor strobe is dead while select A is high
    cpu_start = !CPU_ADDR_STROBE_N && !SELECT.select_low_a_n;
    // Processor strobe takes precedence over controller strobe
    start  = cpu_start || !CTRL_ADDR_STROBE_N;
    st_nxt = st_r;
    base_nxt = base_r;
    cnt_nxt  = cnt_r;
    acc_en = 1'b0;
    acc_a  = ADDR;
    lanes  = SPB_LANE_NONE;
    if (start) begin
      if (sel) begin
        // New burst: address and counter loaded
        st_nxt   = SPB_BURST;
        base_nxt = ADDR;
        cnt_nxt  = ADDR[SPB_CNT_W-1:0];
        acc_en   = 1'b1;
        // Processor-strobe start is always a read cycle
        lanes    = cpu_start ? SPB_LANE_NONE : lane_mask(WRITE);
      end else begin
        // Strobe without select ends any burst
        st_nxt = SPB_DESEL;
      end
    end else if (st_r == SPB_BURST) begin
      // Continue: advance low steps, high holds
      if (!BURST_ADVANCE_N) begin
        cnt_nxt = cnt_r + 2'h1;
      end
      acc_en = 1'b1;
      acc_a  = {base_r[ADDR_W-1:SPB_CNT_W], cnt_nxt};
      lanes  = lane_mask(WRITE);
    end
    acc_rd = acc_en && (lanes == SPB_LANE_NONE);
  end

  // Read pipeline next values
  always_comb begin
    pend_rd_nxt = acc_rd;
    pend_a_nxt  = acc_rd ? acc_a : pend_a_r;
    // Data launched one edge after its address was taken
    dvalid_nxt  = pend_rd_r;
    dout_nxt    = pend_rd_r ? mem[pend_a_r] : dout_r;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_r      <= SPB_DESEL;
      base_r    <= '0;
      cnt_r     <= SPB_CNT_RST;
      pend_rd_r <= 1'b0;
      pend_a_r  <= '0;
      dvalid_r  <= 1'b0;
      dout_r    <= SPB_DOUT_RST;
    end else begin
      st_r      <= st_nxt;
      base_r    <= base_nxt;
      cnt_r     <= cnt_nxt;
      pend_rd_r <= pend_rd_nxt;
      pend_a_r  <= pend_a_nxt;
      dvalid_r  <= dvalid_nxt;
      dout_r    <= dout_nxt;
    end
  end

  // Array write, self-timed on the sampling edge; not reset
  always_ff @(posedge CLK) begin
    for (int i = 0; i < SPB_LANES; i++) begin
      if (RST_N && lanes[i]) begin
        mem[acc_a][i*SPB_LANE_W +: SPB_LANE_W] <= DQ_IN[i*SPB_LANE_W +: SPB_LANE_W];
      end
    end
  end

  // ****************************************
  // Data pins
  // ****************************************
  // Enable follows the pin with no clock; the pipeline keeps the
  // pins undriven while a first read out of deselect is in flight
  assign DQ_OUT = dout_r;
  assign DQ_OE  = !OUT_ENABLE_N && dvalid_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_start_loads_cnt: assert property (start && sel |=> cnt_r == $past(ADDR[1:0]))
    else $error("Counter not loaded from low address bits");
  a_adv_steps: assert property (!start && st_r == SPB_BURST && !BURST_ADVANCE_N
    |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("Counter did not advance");
  a_adv_holds: assert property (!start && BURST_ADVANCE_N |=> $stable(cnt_r))
    else $error("Counter moved without advance");
  a_desel_no_burst: assert property (start && !sel
    |=> st_r == SPB_DESEL && $stable(cnt_r) && !pend_rd_r)
    else $error("Access started while deselected");
  a_ce1_gates_cpu: assert property (!CPU_ADDR_STROBE_N && SELECT.select_low_a_n
    && CTRL_ADDR_STROBE_N |-> !start)
    else $error("Processor strobe honoured with select A high");
  a_cpu_wins: assert property (cpu_start && !CTRL_ADDR_STROBE_N && sel
    |-> lanes == SPB_LANE_NONE)
    else $error("Controller strobe used when processor strobe active");
  a_global_write: assert property (acc_en && !(cpu_start && start && sel)
    && !WRITE.all_bytes_write_n |-> lanes == SPB_LANE_ALL)
    else $error("Global write missed a lane");
  a_lane_qualify: assert property (WRITE.all_bytes_write_n
    && WRITE.byte_write_qualify_n |-> lanes == SPB_LANE_NONE)
    else $error("Lane written without qualify");
  a_read_latency: assert property (acc_rd |-> ##2 dvalid_r)
    else $error("Read data not launched two edges on");
  a_first_read_mask: assert property (acc_rd && st_r == SPB_DESEL |=> !DQ_OE)
    else $error("Pins driven on first read from deselect");
  a_oe_gate: assert property (OUT_ENABLE_N |-> !DQ_OE)
    else $error("Pins driven with output enable high");

  c_full_burst: cover property (start && sel ##1 (!start && !BURST_ADVANCE_N)[*3]);
  c_ctrl_write: cover property (!cpu_start && !CTRL_ADDR_STROBE_N && sel && lanes != 0);
  c_first_read: cover property (acc_rd && st_r == SPB_DESEL ##2 DQ_OE);
  c_both_strobes: cover property (cpu_start && !CTRL_ADDR_STROBE_N && sel);

endmodule

/* tb/spb_bus_master.sv */
`timescale 1ns/1ps
// ********
// Bus master model
// ********
module spb_bus_master #(
  parameter int AW = 6                      // Address width
) (
  // Clock
  input  wire logic                       clk,
  // Bus pins
  output logic [AW-1:0]                   addr,
  output logic                            cpu_n,
  output logic                            ctrl_n,
  output logic                            adv_n,
  output spb_pkg::spb_sel_t               sel,
  output spb_pkg::spb_wr_t                wr,
  output logic [spb_pkg::SPB_DATA_W-1:0]  dq
);
  import spb_pkg::*;
  // Idle bus: deselected, no write enables
  initial begin
    {cpu_n, ctrl_n, adv_n} = 3'h7;
    sel  = 3'h7;
    wr   = 6'h3F;
    addr = '0;
    dq   = '0;
  end
  // One cycle, held until the next rising edge
  task automatic step(input logic [2:0] ckv, input logic [2:0] s, input logic [5:0] w,
                      input logic [AW-1:0] a, input logic [SPB_DATA_W-1:0] d);
    {cpu_n, ctrl_n, adv_n} = ckv;
    sel  = s;
    wr   = w;
    addr = a;
    // Unused data toggles so a stale value never passes
    dq   = (&w[5:4]) ? ~dq : d;
    @(posedge clk);
    #1;
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import spb_pkg::*;
  // ********
  // Stimulus table and state
  // ********
  typedef struct packed {
    logic [5:0]  a;                       // Address
    logic [5:0]  w;                       // Write controls
    logic [35:0] d;                       // Write data
    logic [3:0]  ln;                      // Lanes that change
  } spb_row_t;
  localparam logic [2:0] ON  = 3'h2;      // A low, B high, C low
  localparam logic [2:0] OFF = 3'h7;
  localparam logic [5:0] RD  = 6'h3F;     // No write enables
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        oe_n = 1'b0;
  logic [5:0]  addr;
  logic        cpu_n, ctrl_n, adv_n, dq_oe;
  spb_sel_t    sel;
  spb_wr_t     wr;
  logic [35:0] dq_in, dq_out;
  logic [35:0] mem [64];                  // Shadow array
  int          errors = 0;
  int          compares = 0;
  int          cyc = 0;
  spb_row_t    rows [6] = '{'{6'h05, 6'h1F, 36'h123456789, 4'hF},
    '{6'h05, 6'h2A, 36'hFFFFFFFFF, 4'h5}, '{6'h05, 6'h30, 36'h000000000, 4'h0},
    '{6'h05, 6'h05, 36'h0F0F0F0F0, 4'hF}, '{6'h2A, 6'h1F, 36'h876543210, 4'hF},
    '{6'h2A, 6'h2E, 36'h000000000, 4'h1}};
  always #5 clk = ~clk;
  spb_bus_master #(.AW(6)) spb_bus_master_inst (.clk(clk), .addr(addr), .cpu_n(cpu_n),
    .ctrl_n(ctrl_n), .adv_n(adv_n), .sel(sel), .wr(wr), .dq(dq_in));
  spb_sram_port #(.ADDR_W(6)) spb_sram_port_inst (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
    .CPU_ADDR_STROBE_N(cpu_n), .CTRL_ADDR_STROBE_N(ctrl_n), .BURST_ADVANCE_N(adv_n),
    .SELECT(sel), .WRITE(wr), .OUT_ENABLE_N(oe_n), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE(dq_oe));
  // ********
  // Helpers
  // ********
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic go(input logic [2:0] k, input logic [2:0] s, input logic [5:0] w,
                    input logic [5:0] a, input logic [35:0] d);
    spb_bus_master_inst.step(k, s, w, a, d);
  endtask
  // Write cycle; shadow follows the expected lanes
  task automatic wrt(input logic [2:0] k, input logic [2:0] s, input logic [5:0] w,
                     input logic [5:0] a, input logic [5:0] m, input logic [35:0] d,
                     input logic [3:0] ln);
    go(k, s, w, a, d);
    for (int i = 0; i < 4; i++) if (ln[i]) mem[m][9*i+:9] = d[9*i+:9];
  endtask
  // Read from deselect; pins masked first, data on the next edge
  task automatic rd(input logic [5:0] a);
    go(3'h5, OFF, RD, a, '0);
    go(3'h3, ON, RD, a, '0);
    chk("oe_first", 36'h0, dq_oe);
    go(3'h5, OFF, RD, a, '0);
    chk("dout", mem[a], dq_out);
    chk("oe", 36'h1, dq_oe);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      conclude();
    end
  end
  // ********
  // Main sequence
  // ********
  initial begin
    repeat (16) @(posedge clk);
    #1;
    chk("oe_rst", 36'h0, dq_oe);
    chk("dout_rst", 36'h0, dq_out);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      wrt(3'h5, ON, rows[i].w, rows[i].a, rows[i].a, rows[i].d, rows[i].ln);
      rd(rows[i].a);
      oe_n = 1'b1;
      #1 chk("oe_async", 36'h0, dq_oe);
      @(posedge clk);
      #1 oe_n = 1'b0;
    end
    // Processor strobe while select A high must not end the burst
    go(3'h3, ON, RD, 6'h05, '0);
    go(3'h2, 3'h6, RD, 6'h05, '0);
    chk("dout_cpu_ign", mem[5], dq_out);
    go(3'h7, 3'h6, RD, 6'h05, '0);
    chk("oe_cpu_ign", 36'h1, dq_oe);
    go(3'h1, ON, 6'h1F, 6'h05, 36'hAAAAAAAAA);
    rd(6'h05);
    for (int s = 0; s < 8; s++)
      if (s != int'(ON)) wrt(3'h5, s[2:0], 6'h1F, 6'h05, 6'h05, 36'h0, 4'h0);
    rd(6'h05);
    // Burst write wraps 0D, 0E, 0F, holds, then 0C
    wrt(3'h5, ON, 6'h1F, 6'h0C, 6'h0C, 36'h3C3C3C3C3, 4'hF);
    wrt(3'h5, ON, 6'h1F, 6'h0D, 6'h0D, 36'h111111111, 4'hF);
    wrt(3'h6, ON, 6'h1F, 6'h0D, 6'h0E, 36'h222222222, 4'hF);
    wrt(3'h6, ON, 6'h1F, 6'h0D, 6'h0F, 36'h333333333, 4'hF);
    wrt(3'h7, ON, 6'h1F, 6'h0D, 6'h0F, 36'h444444444, 4'hF);
    wrt(3'h6, ON, 6'h2E, 6'h0D, 6'h0C, 36'h555555555, 4'h1);
    for (int j = 12; j < 16; j++) rd(j[5:0]);
    go(3'h5, OFF, RD, 6'h0F, '0);
    go(3'h3, ON, RD, 6'h0F, '0);
    go(3'h6, ON, RD, 6'h0F, '0);
    chk("burst0", mem[15], dq_out);
    go(3'h5, OFF, RD, 6'h0F, '0);
    chk("burst1", mem[12], dq_out);
    // Reset in mid-read clears the pipeline
    go(3'h3, ON, RD, 6'h05, '0);
    rst_n = 1'b0;
    go(3'h5, OFF, RD, 6'h05, '0);
    go(3'h5, OFF, RD, 6'h05, '0);
    chk("oe_rst2", 36'h0, dq_oe);
    chk("dout_rst2", 36'h0, dq_out);
    rst_n = 1'b1;
    // Array survives reset; reads work again at once
    rd(6'h05);
    conclude();
  end
endmodule
